//--- hdl/sadc_pkg.sv
// Package: register map, fields, reset values and timing for the SAR converter control
package sadc_pkg;
  localparam logic [11:0] ADDR_CONTROL_0 = 12'h000;
  localparam logic [11:0] ADDR_CONTROL_1 = 12'h004;
  localparam logic [11:0] ADDR_CONTROL_2 = 12'h008;
  localparam logic [11:0] ADDR_RESULT_HIGH = 12'h00c;
  localparam logic [11:0] ADDR_RESULT_LOW = 12'h010;
  localparam logic [11:0] ADDR_FLAGS = 12'h014;
  localparam int C0_ENABLE = 0;
  localparam int C0_STATUS = 1;
  localparam int C0_CHAN_LO = 2;
  localparam int C1_CFG_LO = 0;
  localparam int C1_POS_REF = 4;
  localparam int C1_NEG_REF = 5;
  localparam int C2_CLK_LO = 0;
  localparam int C2_ACQ_LO = 3;
  localparam int C2_JUSTIFY = 7;
  localparam int FLAG_DONE = 0;
  localparam int FLAG_IRQ_EN = 1;
  localparam logic [3:0] CHAN_LAST = 4'hc;
  localparam logic [3:0] CFG_FIRST_DIGITAL = 4'h3;
  localparam logic [3:0] CFG_RESET_FUSE_SET = 4'h0;
  localparam logic [3:0] CFG_RESET_FUSE_CLEAR = 4'h7;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] C0_WMASK = 8'h3f;
  localparam logic [7:0] C1_WMASK = 8'h3f;
  localparam logic [7:0] C2_WMASK = 8'hbf;
  localparam int CHANNELS = 13;
  localparam int CHANNELS_SMALL = 10;
  localparam int RESULT_BITS = 10;
  localparam logic [4:0] CONV_PERIODS = 5'd11;
  localparam logic [7:0] CYCLE_DIV = 8'h04;
  localparam logic [7:0] RC_DIV = 8'h40;
  typedef enum logic [1:0] {SADC_IDLE, SADC_DELAY, SADC_ACQ, SADC_CONV} sadc_state_t;
  typedef struct packed {
    logic [3:0] port_analog_config;
    logic neg_ref_select;
    logic pos_ref_select;
  } sadc_refcfg_t;
endpackage

//--- hdl/sadc_core.sv
// Converter control: APB registers, clock select, acquisition and bit sequencer
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// Functional notes
// - Channel field bits 5:2 picks input 0-12; codes 13-15 float.
// - Status bit 1 reads one while converting, zero when idle.
// - Bit 0 of control 0 enables module; resets to zero.
// - Control 1 bit 5 picks negative reference: pin 2 or supply.
// - Control 1 bit 4 picks positive reference: pin 3 or supply.
// - Port field: codes 0-2 all analog, each higher code digitises one more.
// - Power-on port field is 0000 with fuse set, 0111 otherwise.
// - Control 2 bit 7 picks right (1) or left (0) justified result.
// - Acquisition codes give 0,2,4,6,8,12,16,20 conversion-clock periods.
// - Clock codes divide by 2,8,32,4,16,64; 011 and 111 pick RC.
// - RC clock inserts one instruction cycle before clock starts.
// - Conversion during sleep only runs on the RC clock.
// - Result built one bit at a time by successive approximation.
// - Reset restores control and flag registers, disables module, aborts conversion.
// - At end: load result pair, clear status, set done flag.
// - Power-on reset leaves result pair unchanged.
// - Nonzero acquisition time runs between start and conversion.
// - Unimplemented bits read as zero.
// - Small variant has 10 inputs, large 13; channels 5-7 large only.
// - Each conversion takes eleven conversion-clock periods.
// - Code 000 converts at once; sampling resumes after completion.
module sadc_core #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic port_analog_fuse,
  input wire logic sleeping,
  input wire logic comparator_high,
  output logic [3:0] channel_select,
  output logic channel_valid,
  output logic [12:0] channel_analog,
  output logic [1:0] ref_select,
  output logic sample_enable,
  output logic [9:0] dac_code,
  output logic conversion_done_flag,
  output logic conversion_irq
);
  logic [7:0] ctl0_q, ctl1_q, ctl2_q;
  logic [7:0] result_high_q, result_low_q;
  logic done_q, irq_en_q;
  logic cfg_loaded_q;
  sadc_pkg::sadc_state_t state_q;
  logic [7:0] div_cnt_q;
  logic tad_tick;
  logic [4:0] period_cnt_q;
  logic [9:0] sar_q;
  logic [3:0] bit_q;
  logic finish;
  logic wr_en, rd_en;
  logic [7:0] wbyte;
  logic [7:0] div_sel;
  logic rc_sel;
  logic [4:0] acq_periods;
  sadc_pkg::sadc_refcfg_t refcfg;

  function automatic logic [12:0] analog_map(input logic [3:0] cfg);
    logic [12:0] m;
    m = 13'h1fff;
    if (cfg >= sadc_pkg::CFG_FIRST_DIGITAL) begin
      m = 13'h1fff >> (5'(cfg) - 5'(sadc_pkg::CFG_FIRST_DIGITAL) + 5'd1);
    end
    return m;
  endfunction

  // Register map decode
  function automatic logic addr_mapped(input logic [11:0] a);
    logic hit;
    hit = 1'b0;
    case (a)
      sadc_pkg::ADDR_CONTROL_0, sadc_pkg::ADDR_CONTROL_1, sadc_pkg::ADDR_CONTROL_2: hit = 1'b1;
      sadc_pkg::ADDR_RESULT_HIGH, sadc_pkg::ADDR_RESULT_LOW, sadc_pkg::ADDR_FLAGS: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  assign wr_en = psel && penable && pwrite && pstrb[0] && addr_mapped(paddr);
  assign rd_en = psel && !penable && !pwrite;
  assign wbyte = pwdata[7:0];
  assign refcfg = sadc_pkg::sadc_refcfg_t'({ctl1_q[3:0], ctl1_q[sadc_pkg::C1_NEG_REF], ctl1_q[sadc_pkg::C1_POS_REF]});

  always_comb begin
    rc_sel = 1'b0;
    case (ctl2_q[2:0])
      3'h0: div_sel = 8'h02;
      3'h1: div_sel = 8'h08;
      3'h2: div_sel = 8'h20;
      3'h4: div_sel = 8'h04;
      3'h5: div_sel = 8'h10;
      3'h6: div_sel = 8'h40;
      default: begin
        div_sel = sadc_pkg::RC_DIV;
        rc_sel = 1'b1;
      end
    endcase
  end

  always_comb begin
    case (ctl2_q[5:3])
      3'h0: acq_periods = 5'd0;
      3'h1: acq_periods = 5'd2;
      3'h2: acq_periods = 5'd4;
      3'h3: acq_periods = 5'd6;
      3'h4: acq_periods = 5'd8;
      3'h5: acq_periods = 5'd12;
      3'h6: acq_periods = 5'd16;
      default: acq_periods = 5'd20;
    endcase
  end

  assign tad_tick = (div_cnt_q == div_sel - 8'h01) && (rc_sel || !sleeping);
  assign finish = (state_q == sadc_pkg::SADC_CONV) && tad_tick && (period_cnt_q == sadc_pkg::CONV_PERIODS - 5'd1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_q <= 8'h00;
    end else if (state_q == sadc_pkg::SADC_IDLE || state_q == sadc_pkg::SADC_DELAY || tad_tick) begin
      div_cnt_q <= 8'h00;
    end else if (rc_sel || !sleeping) begin
      div_cnt_q <= div_cnt_q + 8'h01;
    end
  end

  // Control 0 write, status and abort
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl0_q <= sadc_pkg::CONTROL_RESET;
    end else if (wr_en && paddr == sadc_pkg::ADDR_CONTROL_0) begin
      ctl0_q[5:0] <= wbyte[5:0] & sadc_pkg::C0_WMASK[5:0];
      ctl0_q[sadc_pkg::C0_STATUS] <= wbyte[sadc_pkg::C0_STATUS] & wbyte[sadc_pkg::C0_ENABLE]
        & (ctl0_q[sadc_pkg::C0_STATUS] | state_q == sadc_pkg::SADC_IDLE) & ~finish;
    end else if (finish || !ctl0_q[sadc_pkg::C0_ENABLE]) begin
      ctl0_q[sadc_pkg::C0_STATUS] <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl1_q <= sadc_pkg::CONTROL_RESET;
      cfg_loaded_q <= 1'b0;
    end else if (!cfg_loaded_q) begin
      cfg_loaded_q <= 1'b1;
      ctl1_q[3:0] <= port_analog_fuse ? sadc_pkg::CFG_RESET_FUSE_SET : sadc_pkg::CFG_RESET_FUSE_CLEAR;
    end else if (wr_en && paddr == sadc_pkg::ADDR_CONTROL_1) begin
      ctl1_q <= wbyte & sadc_pkg::C1_WMASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl2_q <= sadc_pkg::CONTROL_RESET;
    end else if (wr_en && paddr == sadc_pkg::ADDR_CONTROL_2) begin
      ctl2_q <= wbyte & sadc_pkg::C2_WMASK;
    end
  end

  // Sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= sadc_pkg::SADC_IDLE;
      period_cnt_q <= 5'd0;
      sar_q <= 10'h000;
      bit_q <= 4'h0;
    end else if (!ctl0_q[sadc_pkg::C0_ENABLE]) begin
      state_q <= sadc_pkg::SADC_IDLE;
    end else begin
      case (state_q)
        sadc_pkg::SADC_IDLE: begin
          period_cnt_q <= 5'd0;
          if (ctl0_q[sadc_pkg::C0_STATUS]) begin
            if (rc_sel) begin
              state_q <= sadc_pkg::SADC_DELAY;
            end else if (acq_periods == 5'd0) begin
              state_q <= sadc_pkg::SADC_CONV;
            end else begin
              state_q <= sadc_pkg::SADC_ACQ;
            end
          end
        end
        sadc_pkg::SADC_DELAY: begin
          period_cnt_q <= period_cnt_q + 5'd1;
          if (period_cnt_q == 5'(sadc_pkg::CYCLE_DIV) - 5'd1) begin
            period_cnt_q <= 5'd0;
            state_q <= acq_periods == 5'd0 ? sadc_pkg::SADC_CONV : sadc_pkg::SADC_ACQ;
          end
        end
        sadc_pkg::SADC_ACQ: begin
          if (tad_tick) begin
            period_cnt_q <= period_cnt_q + 5'd1;
            if (period_cnt_q == acq_periods - 5'd1) begin
              period_cnt_q <= 5'd0;
              state_q <= sadc_pkg::SADC_CONV;
            end
          end
        end
        sadc_pkg::SADC_CONV: begin
          if (tad_tick) begin
            period_cnt_q <= period_cnt_q + 5'd1;
            if (period_cnt_q == 5'd0) begin
              sar_q <= 10'h200;
              bit_q <= 4'd9;
            end else if (period_cnt_q <= 5'd10) begin
              sar_q[bit_q] <= comparator_high;
              if (bit_q != 4'd0) begin
                sar_q[bit_q - 4'd1] <= 1'b1;
                bit_q <= bit_q - 4'd1;
              end
            end
            if (finish) begin
              state_q <= sadc_pkg::SADC_IDLE;
            end
          end
        end
        default: state_q <= sadc_pkg::SADC_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk) begin
    if (finish) begin
      if (ctl2_q[sadc_pkg::C2_JUSTIFY]) begin
        result_high_q <= {6'h00, sar_q[9:8]};
        result_low_q <= {sar_q[7:1], comparator_high};
      end else begin
        result_high_q <= sar_q[9:2];
        result_low_q <= {sar_q[1], comparator_high, 6'h00};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
      irq_en_q <= 1'b0;
    end else begin
      if (wr_en && paddr == sadc_pkg::ADDR_FLAGS) begin
        done_q <= wbyte[sadc_pkg::FLAG_DONE];
        irq_en_q <= wbyte[sadc_pkg::FLAG_IRQ_EN];
      end
      if (finish) begin
        done_q <= 1'b1;
      end
    end
  end

  // APB read data, one wait-free access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        pslverr <= !addr_mapped(paddr);
      end
      if (rd_en) begin
        case (paddr)
          sadc_pkg::ADDR_CONTROL_0: prdata <= {24'h0, ctl0_q};
          sadc_pkg::ADDR_CONTROL_1: prdata <= {24'h0, ctl1_q};
          sadc_pkg::ADDR_CONTROL_2: prdata <= {24'h0, ctl2_q};
          sadc_pkg::ADDR_RESULT_HIGH: prdata <= {24'h0, result_high_q};
          sadc_pkg::ADDR_RESULT_LOW: prdata <= {24'h0, result_low_q};
          sadc_pkg::ADDR_FLAGS: prdata <= {30'h0, irq_en_q, done_q};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Analog side outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_select <= 4'h0;
      channel_valid <= 1'b0;
      channel_analog <= 13'h0000;
      ref_select <= 2'b00;
      sample_enable <= 1'b0;
      dac_code <= 10'h000;
      conversion_done_flag <= 1'b0;
      conversion_irq <= 1'b0;
    end else begin
      channel_select <= ctl0_q[5:2];
      channel_valid <= ctl0_q[5:2] <= sadc_pkg::CHAN_LAST
        && (LARGE_VARIANT || ctl0_q[5:2] < 4'h5 || ctl0_q[5:2] > 4'h7);
      channel_analog <= analog_map(refcfg.port_analog_config) & (LARGE_VARIANT ? 13'h1fff : 13'h1f1f);
      ref_select[1] <= refcfg.neg_ref_select;
      ref_select[0] <= refcfg.pos_ref_select;
      sample_enable <= ctl0_q[sadc_pkg::C0_ENABLE] && state_q != sadc_pkg::SADC_CONV;
      // Trial code to converter
      dac_code <= sar_q;
      conversion_done_flag <= done_q || finish;
      conversion_irq <= (done_q || finish) && irq_en_q;
    end
  end
endmodule

//--- tb/sadc_core_properties.sv
// Checker: bus and output properties of the converter control
`timescale 1ns/1ps
module sadc_core_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] channel_select,
  input wire logic channel_valid,
  input wire logic [1:0] ref_select,
  input wire logic conversion_done_flag,
  input wire logic conversion_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr1;
  logic [1:0] ref_q;
  assign wr1 = psel && penable && pwrite && pstrb[0] && paddr == sadc_pkg::ADDR_CONTROL_1;
  // Last written reference bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ref_q <= 2'h0;
    else if (wr1) ref_q <= pwdata[5:4];
  end
  AST_READY_NEXT: assert property (psel && !penable |=> pready)
    else $error("No answer after setup");
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("Ready held too long");
  AST_READY_ACCESS: assert property (pready |-> psel && penable && $past(psel) && !$past(penable))
    else $error("Ready outside access phase");
  AST_SLVERR_ZERO: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
    else $error("Bad unmapped read");
  AST_UPPER_ZERO: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("Upper read bits set");
  AST_C0_UNUSED: assert property (pready && !pwrite && paddr == sadc_pkg::ADDR_CONTROL_0 |-> prdata[7:6] == 2'h0)
    else $error("Unused control bits set");
  AST_CHAN_VALID: assert property ($stable(channel_select) && $past(presetn, 2) |-> channel_valid == (channel_select <= sadc_pkg::CHAN_LAST))
    else $error("Channel valid wrong");
  AST_IRQ_FLAG: assert property (conversion_irq |-> conversion_done_flag || $past(conversion_done_flag))
    else $error("Request without flag");
  AST_REF_SEL: assert property ($past(wr1, 2) && !$past(wr1) |-> ref_select == ref_q)
    else $error("Reference select wrong");
endmodule
bind sadc_core sadc_core_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .channel_select(channel_select), .channel_valid(channel_valid), .ref_select(ref_select),
  .conversion_done_flag(conversion_done_flag), .conversion_irq(conversion_irq));

//--- tb/tb.sv
// Testbench: register and conversion sequences for the converter control
`timescale 1ns/1ps
module tb;
  localparam logic [11:0] a_c0 = sadc_pkg::ADDR_CONTROL_0;
  localparam logic [11:0] a_c1 = sadc_pkg::ADDR_CONTROL_1;
  localparam logic [11:0] a_c2 = sadc_pkg::ADDR_CONTROL_2;
  localparam logic [11:0] a_fl = sadc_pkg::ADDR_FLAGS;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic port_analog_fuse = 1'b0;
  logic sleeping = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, comparator_high, channel_valid, sample_enable, conversion_done_flag, conversion_irq;
  logic [3:0] channel_select;
  logic [12:0] channel_analog;
  logic [1:0] ref_select;
  logic [9:0] dac_code;
  logic [9:0] target = 10'h0;
  logic [31:0] rd;
  logic err;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int div, expc, m;
  time t0, done_t;
  int acqp [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  int divs [8] = '{2, 8, 32, 64, 4, 16, 64, 64};
  logic [5:0] cases [5] = '{6'o00, 6'o14, 6'o71, 6'o03, 6'o55};
  always #2 pclk = ~pclk;
  // Comparator keeps a trial bit while input is not below it
  assign comparator_high = (dac_code <= target);
  sadc_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_analog_fuse(port_analog_fuse), .sleeping(sleeping), .comparator_high(comparator_high),
    .channel_select(channel_select), .channel_valid(channel_valid), .channel_analog(channel_analog),
    .ref_select(ref_select), .sample_enable(sample_enable), .dac_code(dac_code),
    .conversion_done_flag(conversion_done_flag), .conversion_irq(conversion_irq));
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      print_verdict();
    end
  end
  always @(negedge pclk) if (conversion_done_flag === 1'b1 && done_t == 0) done_t = $time;
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Request held until ready is sampled high at a rising edge
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    cmp(rd, exp);
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rchk(a_c1, 32'h7);
    apb(1'b1, a_c2, 32'hff);
    rchk(a_c2, 32'hbf);
    apb(1'b1, a_c1, 32'hff);
    rchk(a_c1, 32'h3f);
    cmp(32'(ref_select), 32'h3);
    apb(1'b1, a_c0, 32'hfe);
    rchk(a_c0, 32'h3c);
    rchk(12'h018, 32'h0);
    cmp(32'(err), 32'h1);
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, a_c1, 32'(c));
      apb(1'b1, a_c0, 32'(c << 2));
      repeat (2) @(negedge pclk);
      cmp(32'(channel_valid), 32'(c <= 12));
      cmp(32'(channel_analog), 32'(c <= 2 ? 13'h1fff : 13'h1fff >> (c - 2)));
    end
    apb(1'b1, a_fl, 32'h2);
    for (int i = 0; i < 5; i++) begin
      target <= 10'h2a5 ^ 10'(i * 83);
      apb(1'b1, a_c2, {24'h0, i[0], 1'b0, cases[i]});
      div = divs[cases[i][2:0]];
      expc = (acqp[cases[i][5:3]] + 11) * div + (cases[i][1:0] == 2'h3 ? 4 : 0);
      sleeping <= (cases[i][1:0] == 2'h3);
      done_t = 0;
      apb(1'b1, a_c0, 32'h3 | (i << 2));
      t0 = $time;
      rchk(a_c0, 32'h3 | (i << 2));
      for (int n = 0; n < 2000 && done_t == 0; n++) @(negedge pclk);
      m = int'((done_t - t0 - 2) / 4);
      cmp(32'(m >= expc - div + 1 && m <= expc + 3), 32'h1);
      rchk(a_c0, 32'h1 | (i << 2));
      cmp(32'({conversion_irq, sample_enable}), 32'h3);
      rchk(sadc_pkg::ADDR_RESULT_HIGH, i[0] ? 32'(target[9:8]) : 32'(target[9:2]));
      rchk(sadc_pkg::ADDR_RESULT_LOW, i[0] ? 32'(target[7:0]) : 32'({target[1:0], 6'h0}));
      apb(1'b1, a_fl, 32'h2);
      rchk(a_fl, 32'h2);
      repeat (2 * div) @(posedge pclk);
    end
    apb(1'b1, a_c2, 32'h0);
    sleeping <= 1'b1;
    apb(1'b1, a_c0, 32'h3);
    repeat (60) @(posedge pclk);
    cmp(32'(conversion_done_flag), 32'h0);
    apb(1'b1, a_c0, 32'h0);
    sleeping <= 1'b0;
    repeat (60) @(posedge pclk);
    rchk(a_fl, 32'h2);
    apb(1'b1, a_c2, 32'h3);
    apb(1'b1, a_c0, 32'h3);
    repeat (20) @(posedge pclk);
    presetn <= 1'b0;
    port_analog_fuse <= 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rchk(a_c0, 32'h0);
    rchk(a_c1, 32'h0);
    rchk(a_c2, 32'h0);
    rchk(sadc_pkg::ADDR_RESULT_LOW, {24'h0, target[1:0], 6'h0});
    cmp(32'(sample_enable), 32'h0);
    print_verdict();
  end
endmodule
